// file: fault_annunciation_pkg.sv
// constants, offsets and types shared by the fault annunciation panel
package fault_annunciation_pkg;

  // timing figures in their own units
  localparam int CLK_NS     = 4;
  localparam int TICK_NS    = 1000000;
  localparam int IDLE_MIN   = 10;
  localparam int MS_PER_MIN = 60000;
  localparam int LAMP_MS    = 1000;
  localparam int BLINK_MS   = 500;

  // sizes
  localparam int N_PLED = 6;
  localparam int N_RLY  = 5;
  localparam int N_SRC  = 16;
  localparam int N_FLT  = 20;
  localparam int N_ALM  = 5;
  localparam int N_TRG  = 5;
  localparam int N_CNT  = 16;
  localparam int SEL_W  = 4;

  // counter groups: first index of each group, last is breaker wear
  localparam int CNT_FLT_BASE = 2;
  localparam int CNT_AR_BASE  = 6;
  localparam int CNT_BKR_BASE = 13;
  localparam int CNT_OPEN_MON = 14;
  localparam int CNT_AMPS     = 15;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_LED_SEL = 8'h04;
  localparam logic [7:0] OFF_LATCH   = 8'h08;
  localparam logic [7:0] OFF_STATUS  = 8'h0C;
  localparam logic [7:0] OFF_REC_SEL = 8'h10;
  localparam logic [7:0] OFF_CNT_RST = 8'h14;
  localparam logic [7:0] OFF_CNT_VAL = 8'h18;
  localparam logic [7:0] OFF_FREC0   = 8'h1C;
  localparam logic [7:0] OFF_FREC1   = 8'h20;
  localparam logic [7:0] OFF_FREC2   = 8'h24;
  localparam logic [7:0] OFF_FREC3   = 8'h28;
  localparam logic [7:0] OFF_FREC4   = 8'h2C;
  localparam logic [7:0] OFF_AT_LOG  = 8'h30;
  localparam logic [7:0] OFF_LOG_CNT = 8'h34;

  // field positions
  localparam int CTRL_COL_LSB  = 4;
  localparam int LATCH_RLY_LSB = 8;
  localparam int RSEL_ALM_LSB  = 8;
  localparam int RSEL_TRG_LSB  = 16;
  localparam int RSEL_CNT_LSB  = 24;

  // reset values
  localparam logic [3:0] COL_LAST_RST = 4'hF;

  typedef enum logic [1:0] {SCR_DEFAULT, SCR_MENU, SCR_FAULT} screen_e;

  typedef enum logic [2:0] {
    DEF_CUR_PU, DEF_CUR_AMP, DEF_BREAKER, DEF_RECLOSE, DEF_CTRL_MODE
  } def_screen_e;

  typedef struct packed {
    logic [15:0] angle;
    logic [15:0] vn;
    logic [15:0] i_n;
    logic [15:0] ic;
    logic [15:0] ib;
    logic [15:0] ia;
    logic [15:0] date;
    logic [31:0] time_ms;
    logic [3:0]  pad;
    logic [1:0]  phase;
    logic [1:0]  group;
    logic [7:0]  func;
  } fault_rec_s;

endpackage

// file: fault_annunciation_panel.sv
// front-panel annunciation, records and counters of a feeder relay
// Operation
// - health LED steady when healthy, flashing when the unit has failed
// - ten minutes without any key returns the menu display to default screen
// - setting picks default screen from five options
// - fault lights trip and configured LEDs while present and unacknowledged
// - fault screen shows on fault and stays until any key
// - trip and health LEDs fixed; others driven by selectable source
// - each programmable LED may latch; unlatched LED follows its cause
// - reset key acknowledges: clears latched relays and fault LED
// - after acknowledge the display returns to default screen; a binary-input or remote acknowledge leaves the fault screen up
// - latches clear on reset only when their cause is gone
// - reset from key, binary input, or remote when mode permits
// - remote fault indication bit and remote acknowledge like local
// - keep 20 latest fault records, readable after ack, by number
// - keep 5 latest alarm records, selected by number
// - keep 5 latest start trigger records, selected by number
// - fault record holds function, time, date, group, phase, currents, extras
// - count control, fault, reclose and breaker monitoring events
// - each counter group has its own independent reset
// - reset key at default screen, no start, lights all LEDs about 1s
// - down key at last cell wraps cursor to first cell
//
// Local design decisions: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module fault_annunciation_panel
  import fault_annunciation_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_NS / CLK_NS,
  parameter int unsigned IDLE_TICKS  = IDLE_MIN * MS_PER_MIN
) (
  // clock and reset
  input  wire logic              ref_clk_in,
  input  wire logic              rst_in,
  // avalon-mm slave
  input  wire logic [7:0]        address_in,
  input  wire logic              read_in,
  input  wire logic              write_in,
  input  wire logic [31:0]       writedata_in,
  output logic [31:0]            readdata_out,
  output logic                   waitrequest_out,
  // keypad pulses
  input  wire logic              key_up_in,
  input  wire logic              key_down_in,
  input  wire logic              key_left_in,
  input  wire logic              key_right_in,
  input  wire logic              key_ok_in,
  input  wire logic              key_home_in,
  input  wire logic              key_reset_in,
  // reset and acknowledge sources
  input  wire logic              bin_reset_in,
  input  wire logic              remote_reset_in,
  input  wire logic              remote_permit_in,
  input  wire logic              remote_ack_in,
  // protection side
  input  wire logic              unit_fail_in,
  input  wire logic              fault_in,
  input  wire logic              prot_start_in,
  input  wire logic [N_SRC-1:0]  led_src_in,
  input  wire logic [N_RLY-1:0]  relay_req_in,
  // fault record capture
  input  wire logic [7:0]        flt_func_in,
  input  wire logic [31:0]       flt_time_ms_in,
  input  wire logic [15:0]       flt_date_in,
  input  wire logic [1:0]        flt_group_in,
  input  wire logic [1:0]        flt_phase_in,
  input  wire logic [15:0]       flt_ia_in,
  input  wire logic [15:0]       flt_ib_in,
  input  wire logic [15:0]       flt_ic_in,
  input  wire logic [15:0]       flt_in_in,
  input  wire logic [15:0]       flt_vn_in,
  input  wire logic [15:0]       flt_angle_in,
  // alarm, trigger and counter events
  input  wire logic              alarm_evt_in,
  input  wire logic [15:0]       alarm_code_in,
  input  wire logic              trig_evt_in,
  input  wire logic [15:0]       trig_code_in,
  input  wire logic [N_CNT-2:0]  cnt_evt_in,
  input  wire logic [15:0]       bkr_amps_in,
  // indicators, relays, display
  output logic                   trip_led_out,
  output logic [N_PLED-1:0]      prog_led_out,
  output logic                   health_led_out,
  output logic [N_RLY-1:0]       relay_out,
  output logic                   fault_ind_out,
  output screen_e                screen_out,
  output def_screen_e            default_sel_out,
  output logic [3:0]             cursor_out
);

  localparam logic [17:0] TICK_LAST  = 18'(TICK_CYCLES - 1);
  localparam logic [19:0] IDLE_LAST  = 20'(IDLE_TICKS - 1);
  localparam logic [9:0]  LAMP_LAST  = 10'(LAMP_MS - 1);
  localparam logic [8:0]  BLINK_LAST = 9'(BLINK_MS - 1);
  localparam logic [4:0]  FLT_MAX    = 5'(N_FLT);

  typedef struct packed {
    logic [17:0]                     tick_cnt;
    logic [19:0]                     idle_cnt;
    logic [9:0]                      lamp_cnt;
    logic                            lamp_on;
    logic [8:0]                      blink_cnt;
    logic                            blink;
    logic                            fault_prev;
    logic                            fault_unack;
    logic [N_PLED-1:0]               led_lat;
    logic [N_RLY-1:0]                rly_lat;
    screen_e                         screen;
    logic [3:0]                      cursor;
    def_screen_e                     def_sel;
    logic [3:0]                      col_last;
    logic [N_PLED*SEL_W-1:0]         led_sel;
    logic [N_PLED-1:0]               led_len;
    logic [N_RLY-1:0]                rly_len;
    logic [4:0]                      flt_sel;
    logic [2:0]                      alm_sel;
    logic [2:0]                      trg_sel;
    logic [3:0]                      cnt_sel;
    logic [4:0]                      flt_num;
    fault_rec_s [N_FLT-1:0]          flt_log;
    logic [N_ALM-1:0][15:0]          alm_log;
    logic [N_TRG-1:0][15:0]          trg_log;
    logic [N_CNT-1:0][31:0]          cnt;
    logic                            done;
    logic [31:0]                     rdata;
    logic                            trip_o;
    logic [N_PLED-1:0]               led_o;
    logic                            health_o;
    logic [N_RLY-1:0]                rly_o;
  } state_s;

  state_s q;
  state_s d;

  // counter group of a counter index
  function automatic logic [1:0] grp(input int i);
    if (i < CNT_FLT_BASE) return 2'h0;
    else if (i < CNT_AR_BASE) return 2'h1;
    else if (i < CNT_BKR_BASE) return 2'h2;
    else return 2'h3;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic        tick;
    logic        key_any;
    logic        ack;
    logic        fault_rise;
    logic        lamp_go;
    logic        req;
    logic        wr;
    logic [N_PLED-1:0] cause;
    fault_rec_s  rec;
    fault_rec_s  frec;
    logic [4:0]  fidx;
    // defaults
    d = q;
    cause = '0;
    rec = '0;
    frec = '0;
    fidx = '0;

    tick = (q.tick_cnt == TICK_LAST);
    key_any = key_up_in | key_down_in | key_left_in | key_right_in |
              key_ok_in | key_home_in | key_reset_in;
    // remote latch reset only when control mode allows it
    ack = key_reset_in | bin_reset_in | (remote_reset_in & remote_permit_in) | remote_ack_in;
    fault_rise = fault_in & ~q.fault_prev;
    lamp_go = key_reset_in & (q.screen == SCR_DEFAULT) & ~prot_start_in;
    req = read_in | write_in;
    wr = write_in & q.done;
    d.fault_prev = fault_in;

    // fixed time base shared by all panel timers
    d.tick_cnt = tick ? '0 : q.tick_cnt + 18'h00001;

    // idle timer restarts on any key and parks at its end
    if (key_any) begin
      d.idle_cnt = '0;
    end else if (tick && q.idle_cnt != IDLE_LAST) begin
      d.idle_cnt = q.idle_cnt + 20'h00001;
    end

    // lamp test runs a fixed number of ticks
    if (lamp_go) begin
      d.lamp_on = 1'b1;
      d.lamp_cnt = '0;
    end else if (q.lamp_on && tick) begin
      d.lamp_cnt = q.lamp_cnt + 10'h001;
      if (q.lamp_cnt == LAMP_LAST) d.lamp_on = 1'b0;
    end

    // health blink phase
    if (tick) begin
      d.blink_cnt = (q.blink_cnt == BLINK_LAST) ? '0 : q.blink_cnt + 9'h001;
      if (q.blink_cnt == BLINK_LAST) d.blink = ~q.blink;
    end

    // trip latch: a new fault wins over a same-cycle acknowledge
    d.fault_unack = fault_rise | (q.fault_unack & ~(ack & ~fault_in));

    // programmable LED and relay latches, cleared only once the cause is gone
    for (int i = 0; i < N_PLED; i++) begin
      cause[i] = led_src_in[q.led_sel[i*SEL_W +: SEL_W]];
      d.led_lat[i] = cause[i] | (q.led_lat[i] & ~(ack & ~cause[i]));
    end
    for (int i = 0; i < N_RLY; i++) begin
      d.rly_lat[i] = relay_req_in[i] | (q.rly_lat[i] & ~(ack & ~relay_req_in[i]));
    end

    // registered indicator drive; lamp test forces every LED on, relays unaffected
    d.trip_o = q.fault_unack | q.lamp_on;
    d.led_o = ((q.led_lat & q.led_len) | (cause & ~q.led_len)) | {N_PLED{q.lamp_on}};
    d.health_o = (unit_fail_in ? q.blink : 1'b1) | q.lamp_on;
    d.rly_o = (q.rly_lat & q.rly_len) | (relay_req_in & ~q.rly_len);

    // screen selection; a new fault takes priority over keys
    unique case (q.screen)
      SCR_FAULT: begin
        if (key_any) d.screen = key_reset_in ? SCR_DEFAULT : SCR_MENU;
      end
      SCR_MENU: begin
        if (q.idle_cnt == IDLE_LAST) d.screen = SCR_DEFAULT;
      end
      SCR_DEFAULT: begin
        if (key_any && !key_reset_in) d.screen = SCR_MENU;
      end
    endcase
    if (ack && q.screen != SCR_FAULT) d.screen = SCR_DEFAULT;
    if (fault_rise) d.screen = SCR_FAULT;

    // cursor within a column, wrapping on down from the last cell
    if (key_down_in) begin
      d.cursor = (q.cursor >= q.col_last) ? '0 : q.cursor + 4'h1;
    end else if (key_up_in && q.cursor != '0) begin
      d.cursor = q.cursor - 4'h1;
    end else if (key_home_in) begin
      d.cursor = '0;
    end

    // record logs: shift keeps entry 0 newest and drops the oldest
    rec = '{angle: flt_angle_in, vn: flt_vn_in, i_n: flt_in_in, ic: flt_ic_in,
            ib: flt_ib_in, ia: flt_ia_in, date: flt_date_in, time_ms: flt_time_ms_in,
            pad: '0, phase: flt_phase_in, group: flt_group_in, func: flt_func_in};
    if (fault_rise) begin
      d.flt_log = {q.flt_log[N_FLT-2:0], rec};
      if (q.flt_num != FLT_MAX) d.flt_num = q.flt_num + 5'h01;
    end
    if (alarm_evt_in) d.alm_log = {q.alm_log[N_ALM-2:0], alarm_code_in};
    if (trig_evt_in) d.trg_log = {q.trg_log[N_TRG-2:0], trig_code_in};

    // event counters; a same-cycle event is counted after the group reset clears
    for (int i = 0; i < N_CNT; i++) begin
      if (wr && address_in == OFF_CNT_RST && writedata_in[grp(i)]) d.cnt[i] = '0;
    end
    for (int i = 0; i < N_CNT - 1; i++) begin
      if (cnt_evt_in[i]) d.cnt[i] = d.cnt[i] + 32'h00000001;
    end
    if (cnt_evt_in[CNT_OPEN_MON]) d.cnt[CNT_AMPS] = d.cnt[CNT_AMPS] + {16'h0000, bkr_amps_in};

    // selected fault record, zero when the number is out of range
    fidx = q.flt_sel - 5'h01;
    frec = (q.flt_sel != '0 && q.flt_sel <= q.flt_num) ? q.flt_log[fidx] : '0;

    // bus: one wait cycle, read data latched in it, write applied at accept
    d.done = req & ~q.done;
    if (req && !q.done) begin
      unique case (address_in)
        OFF_CTRL:    d.rdata = {24'h000000, q.col_last, 1'b0, q.def_sel};
        OFF_LED_SEL: d.rdata = {8'h00, q.led_sel};
        OFF_LATCH:   d.rdata = {19'h00000, q.rly_len, 2'h0, q.led_len};
        OFF_STATUS:  d.rdata = {10'h000, q.cursor, q.screen, q.lamp_on, q.fault_unack,
                                1'b0, q.rly_o, q.health_o, q.led_o, q.trip_o};
        OFF_REC_SEL: d.rdata = {4'h0, q.cnt_sel, 5'h00, q.trg_sel, 5'h00, q.alm_sel,
                                3'h0, q.flt_sel};
        OFF_CNT_VAL: d.rdata = q.cnt[q.cnt_sel];
        OFF_FREC0:   d.rdata = frec[31:0];
        OFF_FREC1:   d.rdata = frec[63:32];
        OFF_FREC2:   d.rdata = frec[95:64];
        OFF_FREC3:   d.rdata = frec[127:96];
        OFF_FREC4:   d.rdata = frec[159:128];
        OFF_AT_LOG:  d.rdata = {(q.trg_sel != '0 && q.trg_sel <= 3'(N_TRG)) ?
                                q.trg_log[q.trg_sel - 3'h1] : 16'h0000,
                                (q.alm_sel != '0 && q.alm_sel <= 3'(N_ALM)) ?
                                q.alm_log[q.alm_sel - 3'h1] : 16'h0000};
        OFF_LOG_CNT: d.rdata = {27'h0000000, q.flt_num};
        default:     d.rdata = '0;
      endcase
    end
    if (wr) begin
      unique case (address_in)
        OFF_CTRL: begin
          d.def_sel = def_screen_e'(writedata_in[2:0]);
          d.col_last = writedata_in[CTRL_COL_LSB +: 4];
        end
        OFF_LED_SEL: d.led_sel = writedata_in[N_PLED*SEL_W-1:0];
        OFF_LATCH: begin
          d.led_len = writedata_in[N_PLED-1:0];
          d.rly_len = writedata_in[LATCH_RLY_LSB +: N_RLY];
        end
        OFF_REC_SEL: begin
          d.flt_sel = writedata_in[4:0];
          d.alm_sel = writedata_in[RSEL_ALM_LSB +: 3];
          d.trg_sel = writedata_in[RSEL_TRG_LSB +: 3];
          d.cnt_sel = writedata_in[RSEL_CNT_LSB +: 4];
        end
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      q <= '0;
      q.col_last <= COL_LAST_RST;
      q.screen <= SCR_DEFAULT;
      q.def_sel <= DEF_CUR_PU;
      q.health_o <= 1'b1;
    end else begin
      q <= d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs
  assign waitrequest_out = (read_in | write_in) & ~q.done;
  assign readdata_out = q.rdata;
  assign trip_led_out = q.trip_o;
  assign prog_led_out = q.led_o;
  assign health_led_out = q.health_o;
  assign relay_out = q.rly_o;
  assign fault_ind_out = q.fault_unack;
  assign screen_out = q.screen;
  assign default_sel_out = q.def_sel;
  assign cursor_out = q.cursor;

endmodule // fault_annunciation_panel

// file: fault_annunciation_panel_sva.sv
// assertion checker bound to the fault annunciation panel
`timescale 1ns/1ps
module fault_annunciation_panel_sva
  import fault_annunciation_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = 4,
  parameter int unsigned IDLE_TICKS  = 20
) (
  // clock, reset, bus handshake
  input wire logic    ref_clk_in,
  input wire logic    rst_in,
  input wire logic    read_in,
  input wire logic    write_in,
  input wire logic    waitrequest_out,
  // keys and acknowledge
  input wire logic    key_up_in,
  input wire logic    key_down_in,
  input wire logic    key_left_in,
  input wire logic    key_right_in,
  input wire logic    key_ok_in,
  input wire logic    key_home_in,
  input wire logic    key_reset_in,
  input wire logic    remote_ack_in,
  // causes and indications
  input wire logic    unit_fail_in,
  input wire logic    fault_in,
  input wire logic    trip_led_out,
  input wire logic    health_led_out,
  input wire logic    fault_ind_out,
  input wire screen_e screen_out
);
  // tick phase is free running, so the idle limit allows one extra tick
  localparam int IDLE_LIM  = IDLE_TICKS * TICK_CYCLES + TICK_CYCLES + 3;
  localparam int BLINK_LIM = BLINK_MS * TICK_CYCLES + 8;
  logic any_key;
  int   idle_q;
  int   stk_q;
  logic hl_q;

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  // cycles since the last key, saturating just past the limit
  assign any_key = key_up_in | key_down_in | key_left_in | key_right_in | key_ok_in |
                   key_home_in | key_reset_in;
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || any_key) idle_q <= 0;
    else if (idle_q <= IDLE_LIM) idle_q <= idle_q + 1;
  end

  // cycles the health lamp stood still while the unit is failed
  always_ff @(posedge ref_clk_in) begin
    hl_q <= health_led_out;
    if (rst_in || !unit_fail_in || health_led_out != hl_q) stk_q <= 0;
    else stk_q <= stk_q + 1;
  end

  sequence s_fault_det;
    $rose(fault_in);
  endsequence
  sequence s_bus_answer;
    waitrequest_out ##1 !waitrequest_out;
  endsequence

  a_trip_lit: assert property (s_fault_det |-> ##2 trip_led_out)
    else $error("trip lamp late after fault");
  a_fault_screen: assert property (s_fault_det |=> screen_out == SCR_FAULT && fault_ind_out)
    else $error("fault screen or indication missing");
  a_screen_held: assert property (screen_out == SCR_FAULT && !any_key && !remote_ack_in
    |=> screen_out == SCR_FAULT)
    else $error("fault screen left without a key");
  a_ack_home: assert property (screen_out == SCR_FAULT && key_reset_in && !fault_in
    |=> screen_out == SCR_DEFAULT)
    else $error("no default screen after acknowledge");
  a_ack_clears: assert property (key_reset_in && !fault_in |=> !fault_ind_out)
    else $error("reset key left fault unacknowledged");
  a_remote_ack: assert property (remote_ack_in && !fault_in |=> !fault_ind_out)
    else $error("remote acknowledge ignored");
  a_idle_home: assert property (idle_q >= IDLE_LIM |-> screen_out != SCR_MENU)
    else $error("menu kept past idle limit");
  a_health_on: assert property (!unit_fail_in [*3] |-> health_led_out)
    else $error("health lamp dark on a healthy unit");
  a_health_blink: assert property (stk_q < BLINK_LIM)
    else $error("health lamp not flashing on failed unit");
  a_bus_wait: assert property ($rose(read_in || write_in) |-> s_bus_answer)
    else $error("bus answer not after one wait cycle");
endmodule // fault_annunciation_panel_sva

bind fault_annunciation_panel fault_annunciation_panel_sva #(
  .TICK_CYCLES(TICK_CYCLES),
  .IDLE_TICKS(IDLE_TICKS)
) i_sva (
  .ref_clk_in, .rst_in, .read_in, .write_in, .waitrequest_out, .key_up_in, .key_down_in,
  .key_left_in, .key_right_in, .key_ok_in, .key_home_in, .key_reset_in, .remote_ack_in,
  .unit_fail_in, .fault_in, .trip_led_out, .health_led_out, .fault_ind_out, .screen_out
);

// file: panel_keypad.sv
// operator keypad model: turns press requests into one-cycle key pulses
`timescale 1ns/1ps
module panel_keypad (
  // clock and press request, bits up,down,left,right,ok,home,reset
  input  wire logic       ref_clk_in,
  input  wire logic [6:0] press_in,
  // key pulses to the panel
  output logic [6:0]      key_out
);
  logic [6:0] prev_q = 7'h00;

  // a held button still gives one pulse, as a real key edge would
  always_ff @(posedge ref_clk_in) begin
    prev_q <= press_in;
  end
  assign key_out = press_in & ~prev_q;
endmodule // panel_keypad

// file: tb.sv
// self-checking testbench of the fault annunciation panel
`timescale 1ns/1ps
module tb;
  import fault_annunciation_pkg::*;
  localparam int TK = 4;
  localparam int IT = 20;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] m; logic [31:0] e;} row_s;
  logic ref_clk_in = 1'h0, rst_in = 1'h1, read_in = 1'h0, write_in = 1'h0;
  logic [7:0] address_in = 8'h00, flt_func_in = 8'h00;
  logic [31:0] writedata_in = 32'h0, readdata_out, q;
  logic [6:0] press = 7'h00, key;
  logic bin_reset_in = 1'h0, remote_reset_in = 1'h0, remote_permit_in = 1'h0;
  logic remote_ack_in = 1'h0, unit_fail_in = 1'h0, fault_in = 1'h0, prot_start_in = 1'h0;
  logic alarm_evt_in = 1'h0, trig_evt_in = 1'h0, waitrequest_out, trip_led_out;
  logic health_led_out, fault_ind_out;
  logic [1:0] flt_group_in = 2'h0, flt_phase_in = 2'h0;
  logic [15:0] led_src_in = 16'h0, alarm_code_in = 16'h0, trig_code_in = 16'h0;
  logic [15:0] bkr_amps_in = 16'h0, fv = 16'h1234;
  logic [14:0] cnt_evt_in = 15'h0;
  logic [4:0] relay_req_in = 5'h0, relay_out;
  logic [5:0] prog_led_out;
  logic [3:0] cursor_out;
  screen_e screen_out;
  def_screen_e default_sel_out;
  int miscompares = 0, n_tests = 0, cyc = 0;
  row_s rows[6] = '{'{OFF_CTRL, 32'hF4, 32'hF7, 32'hF4},
    '{OFF_LED_SEL, 32'h543210, 32'hFFFFFF, 32'h543210},
    '{OFF_LATCH, 32'h1F3F, 32'h1F3F, 32'h1F3F}, '{OFF_STATUS, 32'hFFFFFFFF, 32'hFF, 32'h80},
    '{8'h3C, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h0}, '{OFF_LOG_CNT, 32'h5, 32'hFFFFFFFF, 32'h0}};
  int cidx[4] = '{0, 2, 14, 15};
  int cexp[4] = '{2, 1, 1, 256};

  fault_annunciation_panel #(.TICK_CYCLES(TK), .IDLE_TICKS(IT)) i_dut (
    .ref_clk_in, .rst_in, .address_in, .read_in, .write_in, .writedata_in, .readdata_out,
    .waitrequest_out, .key_up_in(key[0]), .key_down_in(key[1]), .key_left_in(key[2]),
    .key_right_in(key[3]), .key_ok_in(key[4]), .key_home_in(key[5]),
    .key_reset_in(key[6]), .bin_reset_in, .remote_reset_in, .remote_permit_in,
    .remote_ack_in, .unit_fail_in, .fault_in, .prot_start_in, .led_src_in, .relay_req_in,
    .flt_func_in, .flt_time_ms_in({fv, fv}), .flt_date_in(fv), .flt_group_in,
    .flt_phase_in, .flt_ia_in(fv), .flt_ib_in(fv), .flt_ic_in(fv), .flt_in_in(fv),
    .flt_vn_in(fv), .flt_angle_in(fv), .alarm_evt_in, .alarm_code_in, .trig_evt_in,
    .trig_code_in, .cnt_evt_in, .bkr_amps_in, .trip_led_out, .prog_led_out,
    .health_led_out, .relay_out, .fault_ind_out, .screen_out, .default_sel_out, .cursor_out);
  panel_keypad i_keypad (.ref_clk_in, .press_in(press), .key_out(key));

  ////////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  always #2 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 25000) begin
      miscompares++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask

  // one bus transfer, held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    address_in <= a;
    writedata_in <= d;
    write_in <= wr;
    read_in <= !wr;
    do @(posedge ref_clk_in); while (waitrequest_out !== 1'h0);
    q = readdata_out;
    write_in <= 1'h0;
    read_in <= 1'h0;
  endtask

  task automatic push(input logic [6:0] m);
    @(posedge ref_clk_in);
    press <= m;
    @(posedge ref_clk_in);
    press <= 7'h00;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    wt(20);
    rst_in <= 1'h0;
    foreach (rows[i]) begin
      bus(1'h1, rows[i].a, rows[i].d);
      bus(1'h0, rows[i].a, 32'h0);
      chk(q & rows[i].m, rows[i].e);
    end
    for (int i = 0; i < 5; i++) begin
      bus(1'h1, OFF_CTRL, 32'h20 | i);
      wt(2);
      chk(default_sel_out, i);
    end
    for (int i = 1; i < 4; i++) begin
      push(7'h02);
      wt(2);
      chk(cursor_out, i % 3);
    end
    wt(IT * TK - 10);
    chk(screen_out, SCR_MENU);
    wt(20);
    chk(screen_out, SCR_DEFAULT);
    // unlatched lamp follows its cause; latched one waits for a reset source
    bus(1'h1, OFF_LATCH, 32'h1F3D);
    led_src_in <= 16'h0002;
    wt(4);
    chk(prog_led_out, 6'h02);
    led_src_in <= 16'h0000;
    wt(4);
    chk(prog_led_out, 6'h00);
    for (int j = 0; j < 3; j++) begin
      led_src_in <= 16'h0001;
      wt(4);
      led_src_in <= 16'h0000;
      wt(4);
      remote_permit_in <= (j == 1);
      remote_reset_in <= (j < 2);
      bin_reset_in <= (j == 2);
      wt(1);
      remote_reset_in <= 1'h0;
      bin_reset_in <= 1'h0;
      wt(4);
      chk(prog_led_out, j == 0);
    end
    // fault with latched lamp and relay, reset refused while causes stand
    led_src_in <= 16'h0001;
    relay_req_in <= 5'h01;
    fault_in <= 1'h1;
    flt_func_in <= 8'hA5;
    wt(4);
    chk({trip_led_out, prog_led_out[0], relay_out[0], fault_ind_out}, 4'hF);
    wt(50);
    chk(screen_out, SCR_FAULT);
    push(7'h40);
    wt(4);
    chk({trip_led_out, prog_led_out[0]}, 2'h3);
    fault_in <= 1'h0;
    led_src_in <= 16'h0000;
    relay_req_in <= 5'h00;
    wt(4);
    chk(relay_out[0], 1'h1);
    push(7'h40);
    wt(4);
    chk({trip_led_out, prog_led_out, health_led_out, relay_out}, 13'h1FE0);
    chk(screen_out, SCR_DEFAULT);
    wt(LAMP_MS * TK + 10);
    chk({trip_led_out, prog_led_out, fault_ind_out}, 8'h00);
    // twenty-one more faults overrun the log
    for (int i = 1; i < 22; i++) begin
      fault_in <= 1'h1;
      flt_func_in <= i;
      flt_group_in <= 2'h2;
      flt_phase_in <= 2'h1;
      wt(2);
      fault_in <= 1'h0;
      wt(2);
    end
    remote_ack_in <= 1'h1;
    wt(1);
    remote_ack_in <= 1'h0;
    wt(2);
    chk(fault_ind_out, 1'h0);
    bus(1'h0, OFF_LOG_CNT, 32'h0);
    chk(q, 32'd20);
    bus(1'h1, OFF_REC_SEL, 32'h1);
    bus(1'h0, OFF_FREC0, 32'h0);
    chk(q & 32'hFFF, 32'h615);
    bus(1'h1, OFF_REC_SEL, 32'd20);
    bus(1'h0, OFF_FREC0, 32'h0);
    chk(q & 32'hFF, 32'h2);
    bus(1'h1, OFF_REC_SEL, 32'd21);
    bus(1'h0, OFF_FREC0, 32'h0);
    chk(q, 32'h0);
    // counter events, then clear the control group alone
    cnt_evt_in <= 15'h4001;
    bkr_amps_in <= 16'h0100;
    wt(1);
    cnt_evt_in <= 15'h0005;
    wt(1);
    cnt_evt_in <= 15'h0000;
    for (int k = 0; k < 5; k++) begin
      if (k == 4) bus(1'h1, OFF_CNT_RST, 32'h1);
      bus(1'h1, OFF_REC_SEL, cidx[k % 4] << 24);
      bus(1'h0, OFF_CNT_VAL, 32'h0);
      chk(q, k == 4 ? 32'h0 : cexp[k]);
    end
    bus(1'h1, OFF_REC_SEL, 32'h02000000);
    bus(1'h0, OFF_CNT_VAL, 32'h0);
    chk(q, 32'h1);
    // six alarms and six triggers back to back
    for (int i = 0; i < 6; i++) begin
      alarm_evt_in <= 1'h1;
      trig_evt_in <= 1'h1;
      alarm_code_in <= 16'hA0 + i;
      trig_code_in <= 16'hB0 + i;
      wt(1);
    end
    alarm_evt_in <= 1'h0;
    trig_evt_in <= 1'h0;
    bus(1'h1, OFF_REC_SEL, 32'h00010500);
    bus(1'h0, OFF_AT_LOG, 32'h0);
    chk(q, 32'h00B500A1);
    bus(1'h1, OFF_REC_SEL, 32'h00050600);
    bus(1'h0, OFF_AT_LOG, 32'h0);
    chk(q, 32'h00B10000);
    // failed unit flashes the health lamp
    unit_fail_in <= 1'h1;
    for (int v = 0; v < 2; v++) begin
      for (int w = 0; w < 2100 && health_led_out !== v[0]; w++) @(posedge ref_clk_in);
      chk(health_led_out, v[0]);
    end
    unit_fail_in <= 1'h0;
    wt(4);
    chk(health_led_out, 1'h1);
    // no lamp test while a protection is started
    prot_start_in <= 1'h1;
    repeat (2) push(7'h40);
    wt(4);
    chk({trip_led_out, prog_led_out}, 7'h00);
    prot_start_in <= 1'h0;
    stop_test();
  end
endmodule // tb
